/* File: dv/fsr_host_model.sv */
/*
 Host-side model: issues one decoded register access at a time.
 Assumes the bank answers a read with a one-cycle rd_valid pulse.
*/
`timescale 1ns/1ps
module fsr_host_model (
    input  wire logic        sys_clk,
    input  wire logic        rd_valid,
    input  wire logic [23:0] rd_data,
    output logic             acc_req,
    output logic             acc_write,
    output logic [7:0]       acc_addr
);
    // Idle bus at time zero
    initial begin
        acc_req = 1'b0;
        acc_write = 1'b0;
        acc_addr = 8'h00;
    end

    // One-cycle request; unanswered access returns unknown data
    task automatic acc(input logic [7:0] a, input logic wr,
                       output logic [23:0] d, output logic ok);
        ok = 1'b0;
        d = 'x;
        @(negedge sys_clk);
        acc_req = 1'b1;
        acc_write = wr;
        acc_addr = a;
        @(negedge sys_clk);
        acc_req = 1'b0;
        acc_addr = ~a; // Released address must not look valid
        repeat (3) begin
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end
            @(negedge sys_clk);
        end
    endtask
endmodule

/* File: dv/tb_fault_status_register_bank.sv */
/*
 Self-checking bench for the fault and status register bank.
 Assumes the host model drives the access port; events come from here.
*/
`timescale 1ns/1ps
module tb_fault_status_register_bank;
    logic        sys_clk, nrst, bsy, tsd, wdok, wreq, fval, act, rec1, lpfp, bst, byp;
    logic        rd_valid, irq_pulse, deep_sleep_req, acc_req, acc_write, ok;
    logic [2:0]  wsel, ren, pg, wake_enable;
    logic [7:0]  acc_addr;
    logic [23:0] sev, lev, rd_data, d;
    int          fail_count, compares, irq_n, ds_n, n;

    fsr_bank DUT (.sys_clk(sys_clk), .nrst(nrst), .acc_req(acc_req),
        .acc_write(acc_write), .acc_addr(acc_addr), .selftest_busy(bsy),
        .selftest_halted_evt(sev[22]), .reg_internal_fail_evt(sev[21:19]),
        .selftest_b_err_evt(sev[18]), .selftest_a_err_evt(sev[17]),
        .analog_selftest_err_evt(sev[16]), .current_mismatch_evt(sev[15]),
        .tsd_evt(tsd), .fault_collector_evt(sev[13]), .wd_trig_fail_evt(sev[12]),
        .wd_trig_ok_evt(wdok), .int_supply_uv_evt(sev[11]), .int_supply_ov_evt(sev[10]),
        .nv_mirror_mismatch_evt(sev[9]), .nv_checksum_evt(sev[8]),
        .ground_loss_evt(sev[7]), .osc_err_evt(sev[6]), .safety_reg_cmp_evt(sev[5]),
        .fsm_cmp_evt(sev[4]), .wake_disable_req(wreq), .wake_disable_sel(wsel),
        .frame_bad_len_evt(lev[21]), .frame_valid_evt(fval),
        .select_timeout_evt(lev[20]), .frame_crc_evt(lev[19]),
        .input_stuck_one_evt(lev[18]), .input_stuck_zero_evt(lev[17]),
        .undef_addr_evt(lev[16]), .boost_fb_high_evt(lev[13]),
        .boost_fb_low_evt(lev[12]), .battery_low_evt(lev[11]),
        .xcvr_supply_low_evt(lev[10]), .temp_warn_evt(lev[9:5]), .mode_active(act),
        .mode_first_recovery(rec1), .lp_to_fp_done_evt(lpfp),
        .boost_switching_in(bst), .bypass_on_in(byp), .reg_enabled(ren),
        .reg_pg_in(pg), .rd_valid(rd_valid), .rd_data(rd_data), .irq_pulse(irq_pulse),
        .deep_sleep_req(deep_sleep_req), .wake_enable(wake_enable));

    fsr_host_model h (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr));

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    // Pulse outputs are counted so tests can compare deltas
    always @(posedge sys_clk) begin
        if (irq_pulse === 1'b1) irq_n++;
        if (deep_sleep_req === 1'b1) ds_n++;
    end

    // Expected word: bit 23 zero, checksum seeded all ones over bits 23..4
    function automatic logic [23:0] w(input logic [23:0] b);
        logic [3:0] c;
        logic       f;
        c = 4'hF;
        b[23] = 1'b0;
        for (int i = 23; i >= 4; i--) begin
            f = c[3] ^ b[i];
            c = {c[2:0], 1'b0} ^ (f ? 4'h3 : 4'h0);
        end
        return {b[23:4], c};
    endfunction

    task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        h.acc(a, 1'b0, d, ok);
    endtask

    task automatic tick(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask

    task automatic pulse(input logic [23:0] s, input logic [23:0] l);
        @(negedge sys_clk);
        sev = s;
        lev = l;
        @(negedge sys_clk);
        sev = '0;
        lev = '0;
    endtask

    // Walk every read-cleared safety and link bit driven straight by an event input: set by its event, cleared by the read
    task automatic t_latch();
        logic [23:0] m;
        for (int b = 4; b <= 22; b++) begin
            m = 24'h00_0001 << b;
            if (b != 14) begin
                pulse(m, '0);
                rd(8'h23);
                chk("safety set", w(m), d);
                rd(8'h23);
                chk("safety clear", w('0), d);
            end
            if ((b >= 5 && b <= 13) || (b >= 16 && b <= 20)) begin
                pulse('0, m);
                rd(8'h24);
                chk("link set", w(m | (b <= 9 ? 24'h00_0010 : '0)), d);
                rd(8'h24);
                chk("link clear", w('0), d);
            end
        end
        $display("latch test done");
    endtask

    // Frame length flag survives reads, falls on a valid frame
    task automatic t_frame();
        pulse('0, 24'h20_0000);
        rd(8'h24);
        chk("len set", w(24'h20_0000), d);
        rd(8'h24);
        chk("len held", w(24'h20_0000), d);
        tick(fval);
        rd(8'h24);
        chk("len clear", w('0), d);
        $display("frame test done");
    endtask

    // Writes, self-test accesses and unmapped reads get no answer
    task automatic t_refuse();
        h.acc(8'h23, 1'b1, d, ok);
        chk("write answered", '0, {23'h0, ok});
        bsy = 1'b1;
        h.acc(8'h25, 1'b0, d, ok);
        bsy = 1'b0;
        chk("busy answered", '0, {23'h0, ok});
        h.acc(8'h26, 1'b0, d, ok);
        chk("unmapped answered", '0, {23'h0, ok});
        rd(8'h24);
        chk("refuse flags", w(24'h00_C000), d);
        $display("refuse test done");
    endtask

    task automatic t_wake();
        chk("wake reset", 24'h7, {21'h0, wake_enable});
        wsel = 3'b001;
        tick(wreq);
        @(negedge sys_clk);
        chk("wake off", 24'h6, {21'h0, wake_enable});
        wsel = 3'b110;
        tick(wreq);
        @(negedge sys_clk);
        chk("wake kept", 24'h6, {21'h0, wake_enable});
        rd(8'h24);
        chk("wake flag", w(24'h40_0000), d);
        $display("wake test done");
    endtask

    // Fourteen failures, a good trigger, then exactly fifteen
    task automatic t_wd();
        tick(wdok);
        n = ds_n;
        repeat (14) pulse(24'h00_1000, '0);
        tick(wdok);
        repeat (14) pulse(24'h00_1000, '0);
        chk("early sleep", 24'(n), 24'(ds_n));
        pulse(24'h00_1000, '0);
        repeat (2) @(negedge sys_clk);
        chk("wd sleep", 24'(n + 1), 24'(ds_n));
        rd(8'h23);
        chk("wd flag", w(24'h00_1000), d);
        repeat (14) pulse(24'h00_1000, '0);
        chk("counter cleared", 24'(n + 1), 24'(ds_n));
        rd(8'h23);
        $display("watchdog test done");
    endtask

    task automatic t_tsd();
        n = ds_n;
        repeat (2) tick(tsd);
        rd(8'h23);
        chk("tsd two", w('0), d);
        tick(tsd);
        repeat (2) @(negedge sys_clk);
        chk("tsd sleep", 24'(n + 1), 24'(ds_n));
        rd(8'h23);
        chk("tsd flag", w(24'h00_4000), d);
        $display("thermal test done");
    endtask

    // Warnings interrupt only in active or first recovery mode
    task automatic t_irq();
        n = irq_n;
        act = 1'b1;
        pulse('0, 24'h00_2000);
        act = 1'b0;
        pulse('0, 24'h00_1000);
        rec1 = 1'b1;
        pulse('0, 24'h00_0800);
        rec1 = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("warn irq", 24'(n + 2), 24'(irq_n));
        rd(8'h24);
        chk("warn bits", w(24'h00_3800), d);
        tick(lpfp);
        repeat (2) @(negedge sys_clk);
        chk("fp irq", 24'(n + 3), 24'(irq_n));
        rd(8'h25);
        chk("fp flag", w(24'h40_0000), d);
        $display("interrupt test done");
    endtask

    task automatic t_live();
        bst = 1'b1;
        byp = 1'b1;
        ren = 3'b101;
        pg = 3'b111;
        repeat (6) @(negedge sys_clk);
        ren = 3'b000;
        rd(8'h25);
        chk("live set", w(24'h1D_0000), d);
        rd(8'h25);
        chk("live kept", w(24'h18_0000), d);
        bst = 1'b0;
        repeat (4) @(negedge sys_clk);
        rd(8'h25);
        chk("live off", w(24'h08_0000), d);
        $display("live test done");
    endtask

    // Event in the very cycle of the clearing read must stay latched
    task automatic t_race();
        fork
            rd(8'h23);
            pulse(24'h00_2000, '0);
        join
        rd(8'h23);
        chk("race kept", w(24'h00_2000), d);
        $display("race test done");
    endtask

    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {sys_clk, nrst, bsy, tsd, wdok, wreq, fval, act, rec1, lpfp, bst, byp} = '0;
        {wsel, ren, pg, sev, lev} = '0;
        {fail_count, compares, irq_n, ds_n, n} = '0;
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_latch();
        t_frame();
        t_refuse();
        t_wake();
        t_wd();
        t_tsd();
        t_irq();
        t_live();
        t_race();
        end_sim();
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule

/* File: rtl/fsr_bank.sv */
/*
 Fault and status register bank: three 24-bit latched status words read
 by the host through the serial link with read-and-clear semantics.
 Assumes event inputs are one-cycle pulses from logic on sys_clk, the
 link logic delivers decoded accesses on acc_*, and the live status
 pins are asynchronous.
*/
`timescale 1ns/1ps
`include "fsr_map.svh"

// Contract
// - Latch self-test halted flag at bit 22
// - Latch per-regulator internal failure, bits 21..19
// - Latch self-test errors at bits 18..16
// - Latch current mismatch at bit 15
// - Third thermal shutdown forces sleep, flag 14
// - Latch fault collector failure at bit 13
// - Latch watchdog failure at bit 12
// - Fifteen watchdog faults: sleep, clear counter, keep flag
// - Latch internal supply under/overvoltage, bits 11..10
// - Latch nonvolatile mismatch and checksum, bits 9..8
// - Latch ground, oscillator, compare errors, bits 7..4
// - Checksum in bits 3..0 of each word
// - Refuse disabling last wake source, flag it
// - Frame length error clears on valid frame
// - Latch link errors at bits 20..16
// - Flag status writes and self-test accesses
// - Latch early warnings, pulse interrupt when active
// - Latch transceiver supply low at bit 10
// - Latch per-cluster temperature warnings, bits 9..5
// - Summary warning is OR of clusters
// - Latch full power reached, raise interrupt
// - Boost and bypass bits are live
module fsr_bank #(
    parameter int WAKE_N = 3
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              acc_req,
    input  wire logic              acc_write,
    input  wire logic [7:0]        acc_addr,
    input  wire logic              selftest_busy,
    input  wire logic              selftest_halted_evt,
    input  wire logic [2:0]        reg_internal_fail_evt,
    input  wire logic              selftest_b_err_evt,
    input  wire logic              selftest_a_err_evt,
    input  wire logic              analog_selftest_err_evt,
    input  wire logic              current_mismatch_evt,
    input  wire logic              tsd_evt,
    input  wire logic              fault_collector_evt,
    input  wire logic              wd_trig_fail_evt,
    input  wire logic              wd_trig_ok_evt,
    input  wire logic              int_supply_uv_evt,
    input  wire logic              int_supply_ov_evt,
    input  wire logic              nv_mirror_mismatch_evt,
    input  wire logic              nv_checksum_evt,
    input  wire logic              ground_loss_evt,
    input  wire logic              osc_err_evt,
    input  wire logic              safety_reg_cmp_evt,
    input  wire logic              fsm_cmp_evt,
    input  wire logic              wake_disable_req,
    input  wire logic [WAKE_N-1:0] wake_disable_sel,
    input  wire logic              frame_bad_len_evt,
    input  wire logic              frame_valid_evt,
    input  wire logic              select_timeout_evt,
    input  wire logic              frame_crc_evt,
    input  wire logic              input_stuck_one_evt,
    input  wire logic              input_stuck_zero_evt,
    input  wire logic              undef_addr_evt,
    input  wire logic              boost_fb_high_evt,
    input  wire logic              boost_fb_low_evt,
    input  wire logic              battery_low_evt,
    input  wire logic              xcvr_supply_low_evt,
    input  wire logic [4:0]        temp_warn_evt,
    input  wire logic              mode_active,
    input  wire logic              mode_first_recovery,
    input  wire logic              lp_to_fp_done_evt,
    input  wire logic              boost_switching_in,
    input  wire logic              bypass_on_in,
    input  wire logic [2:0]        reg_enabled,
    input  wire logic [2:0]        reg_pg_in,
    output logic                   rd_valid,
    output logic [23:0]            rd_data,
    output logic                   irq_pulse,
    output logic                   deep_sleep_req,
    output logic [WAKE_N-1:0]      wake_enable
);
    logic [1:0]              rst_sync_q;
    logic                    rst_n;
    logic [4:0]              pin_meta_q;
    logic [4:0]              pin_sync_q;
    fsr_pkg::fsr_word_t      safety_q, link_q, supply_q;
    fsr_pkg::fsr_word_t      safety_set, link_set, supply_set;
    fsr_pkg::fsr_word_t      safety_clr, link_clr, supply_clr;
    fsr_pkg::fsr_word_t      view;
    fsr_pkg::fsr_sel_e       sel;
    logic [3:0]              crc;
    logic                    rd_hit;
    logic                    rd_valid_q, rd_valid_d;
    fsr_pkg::fsr_word_t      rd_data_q, rd_data_d;
    fsr_pkg::fsr_sel_e       rd_sel_q, rd_sel_d;
    logic                    irq_q, irq_d;
    logic                    sleep_q, sleep_d;
    logic [3:0]              wd_cnt_q, wd_cnt_d;
    logic [1:0]              tsd_cnt_q, tsd_cnt_d;
    logic [WAKE_N-1:0]       wake_en_q, wake_en_d;
    logic                    wd_limit, tsd_limit, wake_refuse;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Live pins are analog comparators, so two flops before use
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end else begin
            pin_meta_q <= {boost_switching_in, bypass_on_in, reg_pg_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Counters that turn repeated faults into a deep sleep request
    always_comb begin
        wd_limit  = wd_trig_fail_evt && (wd_cnt_q == `FSR_WD_FAIL_LIMIT - 4'h1);
        tsd_limit = tsd_evt && (tsd_cnt_q == `FSR_TSD_LIMIT - 2'h1);
        wd_cnt_d  = wd_cnt_q;
        if (wd_limit || wd_trig_ok_evt) begin
            wd_cnt_d = 4'h0;
        end else if (wd_trig_fail_evt) begin
            wd_cnt_d = wd_cnt_q + 4'h1;
        end
        tsd_cnt_d = tsd_limit ? 2'h0 : (tsd_evt ? tsd_cnt_q + 2'h1 : tsd_cnt_q);
        sleep_d   = wd_limit || tsd_limit;
    end

    // Wake enables: last enabled source can never be switched off
    always_comb begin
        wake_refuse = wake_disable_req && ((wake_en_q & ~wake_disable_sel) == '0);
        wake_en_d   = wake_en_q;
        if (wake_disable_req && !wake_refuse) begin
            wake_en_d = wake_en_q & ~wake_disable_sel;
        end
    end

    // Access decode; during link self-test an access is flagged and dropped
    always_comb begin
        sel = fsr_pkg::FSR_SEL_NONE;
        unique case (acc_addr)
            `FSR_OFS_SAFETY: sel = fsr_pkg::FSR_SEL_SAFETY;
            `FSR_OFS_LINK:   sel = fsr_pkg::FSR_SEL_LINK;
            `FSR_OFS_SUPPLY: sel = fsr_pkg::FSR_SEL_SUPPLY;
            default:         sel = fsr_pkg::FSR_SEL_NONE;
        endcase
        rd_hit = acc_req && !acc_write && !selftest_busy && (sel != fsr_pkg::FSR_SEL_NONE);
    end

    // Read views; reserved bits forced low, summary and live bits derived
    always_comb begin
        view = '0;
        unique case (sel)
            fsr_pkg::FSR_SEL_SAFETY: view = {1'b0, safety_q[22:4], 4'h0};
            fsr_pkg::FSR_SEL_LINK:   view = {1'b0, link_q[22:5], |link_q[9:5], 4'h0};
            fsr_pkg::FSR_SEL_SUPPLY: view = {1'b0, supply_q[22], 1'b0, pin_sync_q[4:3],
                                             supply_q[18:16], 16'h0000};
            fsr_pkg::FSR_SEL_NONE:   view = '0;
        endcase
        view[`FSR_RESERVED_BIT] = 1'b0;
    end

    fsr_crc4 #(
        .SEED (`FSR_CRC_SEED)
    ) u_crc (
        .data (view[23:4]),
        .crc  (crc)
    );

    // Read response and clear masks: only bits returned as set are cleared, except the frame length bit, cleared by a valid frame
    always_comb begin
        rd_valid_d = rd_hit;
        rd_data_d  = rd_hit ? {view[23:4], crc} : rd_data_q;
        rd_sel_d   = rd_hit ? sel : rd_sel_q;
        safety_clr = (rd_hit && sel == fsr_pkg::FSR_SEL_SAFETY) ?
                     (view & `FSR_CLR_SAFETY) : '0;
        link_clr   = (rd_hit && sel == fsr_pkg::FSR_SEL_LINK) ? (view & `FSR_CLR_LINK) : '0;
        supply_clr = (rd_hit && sel == fsr_pkg::FSR_SEL_SUPPLY) ? (view & `FSR_CLR_SUPPLY) : '0;
        link_clr[`FSR_B_FRAME_LEN] = frame_valid_evt;
    end

    // Event inputs mapped onto the latched bit positions
    always_comb begin
        safety_set = '0;
        safety_set[`FSR_B_SELFTEST_HALT] = selftest_halted_evt;
        safety_set[`FSR_B_REG3_FAIL -: 3] = {reg_internal_fail_evt[2],
                                             reg_internal_fail_evt[1],
                                             reg_internal_fail_evt[0]};
        safety_set[`FSR_B_SELFTEST_B]     = selftest_b_err_evt;
        safety_set[`FSR_B_SELFTEST_A]     = selftest_a_err_evt;
        safety_set[`FSR_B_ANALOG_ST]      = analog_selftest_err_evt;
        safety_set[`FSR_B_CUR_MISMATCH]   = current_mismatch_evt;
        safety_set[`FSR_B_SLEEP_OVERTEMP] = tsd_limit;
        safety_set[`FSR_B_FAULT_COLL]     = fault_collector_evt;
        safety_set[`FSR_B_WD_FAIL]        = wd_trig_fail_evt;
        safety_set[`FSR_B_INT_UV]         = int_supply_uv_evt;
        safety_set[`FSR_B_INT_OV]         = int_supply_ov_evt;
        safety_set[`FSR_B_NV_MIRROR]      = nv_mirror_mismatch_evt;
        safety_set[`FSR_B_NV_CHECKSUM]    = nv_checksum_evt;
        safety_set[`FSR_B_GND_LOSS]       = ground_loss_evt;
        safety_set[`FSR_B_OSC_ERR]        = osc_err_evt;
        safety_set[`FSR_B_SAFETY_CMP]     = safety_reg_cmp_evt;
        safety_set[`FSR_B_FSM_CMP]        = fsm_cmp_evt;

        link_set = '0;
        link_set[`FSR_B_WAKE_REFUSED] = wake_refuse;
        link_set[`FSR_B_FRAME_LEN]    = frame_bad_len_evt;
        link_set[`FSR_B_SEL_TIMEOUT]  = select_timeout_evt;
        link_set[`FSR_B_FRAME_CRC]    = frame_crc_evt;
        link_set[`FSR_B_STUCK_ONE]    = input_stuck_one_evt;
        link_set[`FSR_B_STUCK_ZERO]   = input_stuck_zero_evt;
        link_set[`FSR_B_UNDEF_ADDR]   = undef_addr_evt;
        link_set[`FSR_B_STATUS_WRITE] = acc_req && acc_write && !selftest_busy &&
                                        (sel != fsr_pkg::FSR_SEL_NONE);
        link_set[`FSR_B_ACC_SELFTEST] = acc_req && selftest_busy;
        link_set[`FSR_B_BOOST_HIGH]   = boost_fb_high_evt;
        link_set[`FSR_B_BOOST_LOW]    = boost_fb_low_evt;
        link_set[`FSR_B_BATT_LOW]     = battery_low_evt;
        link_set[`FSR_B_XCVR_LOW]     = xcvr_supply_low_evt;
        link_set[`FSR_B_TEMP_CL_LO +: 5] = temp_warn_evt;

        supply_set = '0;
        supply_set[`FSR_B_FULL_POWER] = lp_to_fp_done_evt;
        supply_set[`FSR_B_PG_LO +: 3] = reg_enabled & pin_sync_q[2:0];
    end

    // Interrupt pulse for early warnings in active modes and full power
    always_comb begin
        irq_d = ((mode_active || mode_first_recovery) &&
                 (boost_fb_high_evt || boost_fb_low_evt || battery_low_evt)) ||
                lp_to_fp_done_evt;
    end

    fsr_sticky #(.W(24)) u_safety (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .set   (safety_set),
        .clr   (safety_clr),
        .q     (safety_q)
    );

    fsr_sticky #(.W(24)) u_link (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .set   (link_set),
        .clr   (link_clr),
        .q     (link_q)
    );

    fsr_sticky #(.W(24)) u_supply (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .set   (supply_set),
        .clr   (supply_clr),
        .q     (supply_q)
    );

    // Control and response registers; all wake sources enabled out of reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
            rd_sel_q   <= fsr_pkg::FSR_SEL_NONE;
            irq_q      <= 1'b0;
            sleep_q    <= 1'b0;
            wd_cnt_q   <= 4'h0;
            tsd_cnt_q  <= 2'h0;
            wake_en_q  <= '1;
        end else begin
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            rd_sel_q   <= rd_sel_d;
            irq_q      <= irq_d;
            sleep_q    <= sleep_d;
            wd_cnt_q   <= wd_cnt_d;
            tsd_cnt_q  <= tsd_cnt_d;
            wake_en_q  <= wake_en_d;
        end
    end

    assign rd_valid       = rd_valid_q;
    assign rd_data        = rd_data_q;
    assign irq_pulse      = irq_q;
    assign deep_sleep_req = sleep_q;
    assign wake_enable    = wake_en_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_wd_flag_latch: assert property (wd_trig_fail_evt |=> safety_q[12])
        else $error("watchdog failure not latched");
    a_wd_sleep_keep: assert property (wd_limit |=>
        (deep_sleep_req && wd_cnt_q == 4'h0 && safety_q[12]))
        else $error("watchdog limit did not sleep or clear counter");
    a_tsd_third_sleep: assert property (tsd_evt && tsd_cnt_q == 2'h2 |=>
        (safety_q[14] && deep_sleep_req))
        else $error("third thermal shutdown did not force sleep");
    a_len_err_hold: assert property (link_q[21] && !frame_valid_evt |=> link_q[21])
        else $error("frame length error lost without valid frame");
    a_summary_or_bit: assert property (rd_valid && rd_sel_q == fsr_pkg::FSR_SEL_LINK |->
        rd_data[4] == |rd_data[9:5])
        else $error("summary warning differs from clusters");
    a_reserved_zero: assert property (rd_valid |-> !rd_data[23])
        else $error("reserved bit read as one");
    a_live_boost_bit: assert property (rd_valid && rd_sel_q == fsr_pkg::FSR_SEL_SUPPLY |->
        rd_data[20] == $past(pin_sync_q[4]))
        else $error("boost bit not live");
    a_refuse_last_wake: assert property (wake_refuse |=>
        (wake_enable == $past(wake_en_q) && link_q[22]))
        else $error("last wake source disable not refused");
    a_event_beats_clear: assert property (rd_hit && sel == fsr_pkg::FSR_SEL_SAFETY &&
        fault_collector_evt |=> safety_q[13])
        else $error("event lost during read and clear");
    a_warn_irq_pulse: assert property (boost_fb_high_evt && mode_active |=> irq_pulse)
        else $error("early warning gave no interrupt");
    a_read_clears: assert property (rd_hit && sel == fsr_pkg::FSR_SEL_SAFETY &&
        safety_q[12] && !wd_trig_fail_evt |=> !safety_q[12] && rd_data[12])
        else $error("read did not clear returned bit");

    c_read_clear:  cover property (rd_hit ##1 rd_valid && rd_data[22:4] != '0);
    c_wd_sleep:    cover property (wd_limit ##1 deep_sleep_req);
    c_wake_refuse: cover property (wake_refuse);
    c_full_power:  cover property (lp_to_fp_done_evt ##1 irq_pulse);
endmodule

/* File: rtl/fsr_crc4.sv */
/*
 Four-bit checksum over the twenty data bits of a status word,
 polynomial x^4+x+1, most significant bit first.
 Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module fsr_crc4 #(
    parameter logic [3:0] SEED = 4'hF
) (
    input  wire logic [19:0] data,
    output logic      [3:0]  crc
);
    // Bit-serial shift unrolled by the loop
    always_comb begin
        logic [3:0] c;
        logic       fb;
        c  = SEED;
        fb = 1'b0;
        for (int i = 19; i >= 0; i--) begin
            fb = c[3] ^ data[i];
            c  = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
        end
        crc = c;
    end
endmodule

/* File: rtl/fsr_map.svh */
/*
 Register offsets, bit positions, clear masks and counts of the fault and
 status register bank. Assumes inclusion by bare name from rtl/.
*/
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// Register offsets on the serial link
`define FSR_OFS_SAFETY       8'h23
`define FSR_OFS_LINK         8'h24
`define FSR_OFS_SUPPLY       8'h25

// First register bits
`define FSR_B_SELFTEST_HALT  22
`define FSR_B_REG3_FAIL      21
`define FSR_B_SELFTEST_B     18
`define FSR_B_SELFTEST_A     17
`define FSR_B_ANALOG_ST      16
`define FSR_B_CUR_MISMATCH   15
`define FSR_B_SLEEP_OVERTEMP 14
`define FSR_B_FAULT_COLL     13
`define FSR_B_WD_FAIL        12
`define FSR_B_INT_UV         11
`define FSR_B_INT_OV         10
`define FSR_B_NV_MIRROR      9
`define FSR_B_NV_CHECKSUM    8
`define FSR_B_GND_LOSS       7
`define FSR_B_OSC_ERR        6
`define FSR_B_SAFETY_CMP     5
`define FSR_B_FSM_CMP        4

// Second register bits
`define FSR_B_WAKE_REFUSED   22
`define FSR_B_FRAME_LEN      21
`define FSR_B_SEL_TIMEOUT    20
`define FSR_B_FRAME_CRC      19
`define FSR_B_STUCK_ONE      18
`define FSR_B_STUCK_ZERO     17
`define FSR_B_UNDEF_ADDR     16
`define FSR_B_STATUS_WRITE   15
`define FSR_B_ACC_SELFTEST   14
`define FSR_B_BOOST_HIGH     13
`define FSR_B_BOOST_LOW      12
`define FSR_B_BATT_LOW       11
`define FSR_B_XCVR_LOW       10
`define FSR_B_TEMP_CL_LO     5
`define FSR_B_TEMP_SUMMARY   4

// Third register bits
`define FSR_B_FULL_POWER     22
`define FSR_B_BOOST_LIVE     20
`define FSR_B_BYPASS_LIVE    19
`define FSR_B_PG_LO          16

// Field positions
`define FSR_RESERVED_BIT     23
`define FSR_CRC_MSB          3

// Bits a read-and-clear access may clear
`define FSR_CLR_SAFETY       24'h7F_FFF0
`define FSR_CLR_LINK         24'h5F_FFE0
`define FSR_CLR_SUPPLY       24'h47_0000

// Counts and checksum seed
`define FSR_WD_FAIL_LIMIT    4'hF
`define FSR_TSD_LIMIT        2'h3
`define FSR_CRC_SEED         4'hF

`endif

/* File: rtl/fsr_pkg.sv */
/*
 Types shared by the fault and status register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fsr_pkg;
    typedef logic [23:0] fsr_word_t;

    // Which status register an access selects
    typedef enum logic [1:0] {
        FSR_SEL_NONE   = 2'b00,
        FSR_SEL_SAFETY = 2'b01,
        FSR_SEL_LINK   = 2'b10,
        FSR_SEL_SUPPLY = 2'b11
    } fsr_sel_e;
endpackage

/* File: rtl/fsr_sticky.sv */
/*
 Vector of latched event flags with per-bit clear.
 Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module fsr_sticky #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    // Set beats clear so an event during a read is not lost
    always_comb begin
        q_d = (q_q & ~clr) | set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule
